// >>> pkg/mic_pkg.sv
package mic_pkg;

  // apb register map, byte addresses
  localparam logic [7:0] MIC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] MIC_ADDR_OUT = 8'h04;
  localparam logic [7:0] MIC_ADDR_IN = 8'h08;
  localparam logic [7:0] MIC_ADDR_BAUD = 8'h0c;
  localparam logic [7:0] MIC_ADDR_START = 8'h10;
  localparam logic [7:0] MIC_ADDR_DISP = 8'h14;

  // control register fields
  localparam int MIC_CTRL_MODE_LSB = 0;
  localparam int MIC_CTRL_MODE_W = 4;
  localparam int MIC_CTRL_PWR_BIT = 4;
  localparam int MIC_CTRL_MOTOR_BIT = 5;
  localparam int MIC_CTRL_WAIT_EN_BIT = 8;
  localparam int MIC_CTRL_WAIT_LSB = 12;
  localparam int MIC_CTRL_WAIT_W = 4;
  localparam logic [31:0] MIC_CTRL_RESET = 32'h0000_0000;

  // mode threshold for coded program numbers
  localparam logic [3:0] MIC_MODE_CODED = 4'ha;

  // input numbering (0-based index of input n is n-1)
  localparam int MIC_NUM_IN = 12;
  localparam int MIC_NUM_OUT = 8;
  localparam int MIC_START_IDX = 7;
  localparam int MIC_CODE_LSB = 8;

  // baud rates
  localparam logic [17:0] MIC_BAUD_2400 = 18'd2400;
  localparam logic [17:0] MIC_BAUD_4800 = 18'd4800;
  localparam logic [17:0] MIC_BAUD_9600 = 18'd9600;
  localparam logic [17:0] MIC_BAUD_19200 = 18'd19200;
  localparam logic [17:0] MIC_BAUD_38400 = 18'd38400;
  localparam logic [17:0] MIC_BAUD_FREE = 18'd0;
  // serial character format
  localparam logic [3:0] MIC_DATA_BITS = 4'h8;
  localparam logic [1:0] MIC_STOP_BITS = 2'h1;
  localparam logic MIC_PARITY_EN = 1'b0;

  // timing
  localparam int MIC_CLK_HZ = 50000000;
  localparam int MIC_FLASH_MS = 250;
  localparam int MIC_FLASH_CYC = MIC_CLK_HZ / 1000 * MIC_FLASH_MS;

  // display codes: digit = 0..9, blank = 4'hf
  localparam logic [3:0] MIC_DIG_BLANK = 4'hf;
  localparam logic [3:0] MIC_DIG_ZERO = 4'h0;
  localparam logic [3:0] MIC_DIG_ONE = 4'h1;

endpackage

// >>> design/mic_seg_enc.sv
`timescale 1ns/10ps
// bcd digit to 7-segment pattern, segments gfedcba, active high
module mic_seg_enc
  import mic_pkg::*;
(
  input wire logic [3:0] digit,
  output logic [6:0] seg
);

  // blank for anything outside 0..9
  always_comb
  begin
    unique case (digit)
      4'h0: seg = 7'h3f;
      4'h1: seg = 7'h06;
      4'h2: seg = 7'h5b;
      4'h3: seg = 7'h4f;
      4'h4: seg = 7'h66;
      4'h5: seg = 7'h6d;
      4'h6: seg = 7'h7d;
      4'h7: seg = 7'h07;
      4'h8: seg = 7'h7f;
      4'h9: seg = 7'h6f;
      default: seg = 7'h00;
    endcase
  end

endmodule // mic_seg_enc

// >>> design/mic_io_top.sv
`timescale 1ns/10ps
// Notes on behaviour
// R1: each of the 8 outputs is active low: asserted pulls the line low, else released.
// R2: mode below 10 treats inputs 9-12 as plain inputs, mode 10 or more as a program number.
// R3: the program number takes input 9 as bit 0 up to input 12 as bit 3.
// R4: in coded modes a rising input 8 starts the program numbered 1-15 on inputs 9-12.
// R5: both serial links use 8 data bits, no parity and one stop bit.
// R6: the configuration switch is caught once after reset and held until the next one.
// R7: switch bits 7/8 pick rs232 rate: off/off 9600, off/on 4800, on/off 2400, on/on 19200.
// R8: switch bits 5/6 pick rs485 rate: off/off 19200, on/off 9600, off/on 38400, on/on free.
// R9: display shows a steady 0 while the power stage is off.
// R10: display shows a steady 1 while the power stage is on and the motor active.
// R11: while waiting for input 1-12 the display flashes that two-digit number.
// R12: a start request with program number zero is ignored.
module mic_io_top
  import mic_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [11:0] PLC_IN,
  input wire logic [7:0] CONFIG_DIP_SWITCH,
  output logic [7:0] PLC_OUT_N,
  output logic [7:0] PLC_OUT_OE,
  output logic [6:0] SEG_TENS,
  output logic [6:0] SEG_ONES,
  output logic START_PULSE,
  output logic [3:0] START_PROG,
  output logic [17:0] RS232_BAUD,
  output logic [17:0] RS485_BAUD,
  output logic [3:0] SERIAL_DATA_BITS,
  output logic SERIAL_PARITY_EN,
  output logic [1:0] SERIAL_STOP_BITS
);

  // two-flop synchronisers for pins
  logic [11:0] in_ff1_q, in_s2_q;
  logic [7:0] sw_ff1_q, sw_s2_q;
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      in_ff1_q <= 12'h000;
      in_s2_q <= 12'h000;
      sw_ff1_q <= 8'h00;
      sw_s2_q <= 8'h00;
    end
    else
    begin
      in_ff1_q <= PLC_IN;
      in_s2_q <= in_ff1_q;
      sw_ff1_q <= CONFIG_DIP_SWITCH;
      sw_s2_q <= sw_ff1_q;
    end
  end

  // switch bit n (1-based) is sw[n-1], 1 = on
  function automatic logic [17:0] rs232_rate(input logic [7:0] sw);
    unique case ({sw[6], sw[7]})
      2'b00: rs232_rate = MIC_BAUD_9600;
      2'b01: rs232_rate = MIC_BAUD_4800;
      2'b10: rs232_rate = MIC_BAUD_2400;
      2'b11: rs232_rate = MIC_BAUD_19200;
    endcase
  endfunction

  function automatic logic [17:0] rs485_rate(input logic [7:0] sw);
    unique case ({sw[4], sw[5]})
      2'b00: rs485_rate = MIC_BAUD_19200;
      2'b10: rs485_rate = MIC_BAUD_9600;
      2'b01: rs485_rate = MIC_BAUD_38400;
      2'b11: rs485_rate = MIC_BAUD_FREE;
    endcase
  endfunction

  // switch capture: waits for the synchroniser to fill, then freezes
  logic [1:0] cap_cnt_q, cap_cnt_d;
  logic cap_done_q, cap_done_d;
  logic [7:0] sw_lat_q, sw_lat_d;
  always_comb
  begin
    cap_cnt_d = cap_cnt_q;
    cap_done_d = cap_done_q;
    sw_lat_d = sw_lat_q;
    if (!cap_done_q)
    begin
      // two edges of fill so the latch never sees reset zeros
      if (cap_cnt_q == 2'h2)
      begin
        sw_lat_d = sw_s2_q; // see R6
        cap_done_d = 1'b1; // see R6
      end
      else
        cap_cnt_d = cap_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      cap_cnt_q <= 2'h0;
      cap_done_q <= 1'b0;
      sw_lat_q <= 8'h00;
    end
    else
    begin
      cap_cnt_q <= cap_cnt_d;
      cap_done_q <= cap_done_d;
      sw_lat_q <= sw_lat_d;
    end
  end

  // rates registered from the frozen switch value
  logic [17:0] r232_q, r485_q;
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      r232_q <= MIC_BAUD_9600;
      r485_q <= MIC_BAUD_19200;
    end
    else
    begin
      r232_q <= rs232_rate(sw_lat_q); // see R7
      r485_q <= rs485_rate(sw_lat_q); // see R8
    end
  end
  assign RS232_BAUD = r232_q;
  assign RS485_BAUD = r485_q;

  // fixed character format for both links
  assign SERIAL_DATA_BITS = MIC_DATA_BITS; // see R5
  assign SERIAL_PARITY_EN = MIC_PARITY_EN; // see R5
  assign SERIAL_STOP_BITS = MIC_STOP_BITS; // see R5

  // apb registers
  logic [31:0] ctrl_q, ctrl_d;
  logic [7:0] out_q, out_d;
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;
  logic [3:0] last_prog_q, last_prog_d;
  logic [3:0] start_cnt_q, start_cnt_d;
  logic acc;
  logic [3:0] mode;
  logic coded;
  logic [3:0] prog_num;
  logic [11:0] plain_in;
  logic st_prev_q, st_prev_d;
  logic st_fire;

  assign acc = PSEL && PENABLE;
  assign mode = ctrl_q[MIC_CTRL_MODE_LSB +: MIC_CTRL_MODE_W];
  assign coded = (mode >= MIC_MODE_CODED); // see R2
  assign prog_num = in_s2_q[MIC_CODE_LSB +: 4]; // see R3

  // coded inputs read as zero in the plain view while coded
  always_comb
  begin
    plain_in = in_s2_q;
    if (coded)
      plain_in[MIC_CODE_LSB +: 4] = 4'h0; // see R2
  end

  // start on rising input 8, coded mode, nonzero number only
  assign st_fire = coded && in_s2_q[MIC_START_IDX] && !st_prev_q
                   && (prog_num != 4'h0); // see R4, see R12

  always_comb
  begin
    ctrl_d = ctrl_q;
    out_d = out_q;
    rdata_d = rdata_q;
    err_d = 1'b0;
    last_prog_d = last_prog_q;
    start_cnt_d = start_cnt_q;
    st_prev_d = in_s2_q[MIC_START_IDX];
    if (st_fire)
    begin
      last_prog_d = prog_num; // see R4
      start_cnt_d = start_cnt_q + 4'h1;
    end
    // zero-wait slave: answer lands on the access cycle
    if (PSEL && !PENABLE)
    begin
      rdata_d = 32'h0000_0000;
      unique case (PADDR)
        MIC_ADDR_CTRL: rdata_d = ctrl_q;
        MIC_ADDR_OUT: rdata_d = {24'h000000, out_q};
        MIC_ADDR_IN: rdata_d = {20'h00000, plain_in};
        MIC_ADDR_BAUD: rdata_d = {14'h0000, sw_lat_q[7:4], r232_q[17:4]};
        MIC_ADDR_START: rdata_d = {24'h000000, start_cnt_q, last_prog_q};
        MIC_ADDR_DISP: rdata_d = {18'h00000, SEG_TENS, SEG_ONES};
        default: err_d = 1'b1;
      endcase
    end
    if (acc && PWRITE)
    begin
      unique case (PADDR)
        MIC_ADDR_CTRL: ctrl_d = PWDATA;
        MIC_ADDR_OUT: out_d = PWDATA[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ctrl_q <= MIC_CTRL_RESET;
      out_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
      last_prog_q <= 4'h0;
      start_cnt_q <= 4'h0;
      st_prev_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      out_q <= out_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
      last_prog_q <= last_prog_d;
      start_cnt_q <= start_cnt_d;
      st_prev_q <= st_prev_d;
    end
  end

  assign PREADY = 1'b1;
  assign PRDATA = rdata_q;
  assign PSLVERR = acc && err_q;

  // start pulse and number, registered
  logic st_pulse_q;
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
      st_pulse_q <= 1'b0;
    else
      st_pulse_q <= st_fire;
  end
  assign START_PULSE = st_pulse_q;
  assign START_PROG = last_prog_q;

  // open collector: asserted bit drives low, else released
  assign PLC_OUT_N = 8'h00; // see R1
  assign PLC_OUT_OE = out_q; // see R1

  // flash timer for the waiting display
  logic [31:0] fl_cnt_q, fl_cnt_d;
  logic fl_on_q, fl_on_d;
  always_comb
  begin
    fl_cnt_d = fl_cnt_q + 32'h1;
    fl_on_d = fl_on_q;
    if (fl_cnt_q == 32'(MIC_FLASH_CYC - 1))
    begin
      fl_cnt_d = 32'h0;
      fl_on_d = !fl_on_q;
    end
  end
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      fl_cnt_q <= 32'h0;
      fl_on_q <= 1'b1;
    end
    else
    begin
      fl_cnt_q <= fl_cnt_d;
      fl_on_q <= fl_on_d;
    end
  end

  // display selection, waiting takes priority over power state
  logic [3:0] dig_t_d, dig_o_d, dig_t_q, dig_o_q;
  logic [3:0] wait_in;
  logic wait_ok;
  assign wait_in = ctrl_q[MIC_CTRL_WAIT_LSB +: MIC_CTRL_WAIT_W];
  assign wait_ok = ctrl_q[MIC_CTRL_WAIT_EN_BIT] && (wait_in >= 4'h1) && (wait_in <= 4'hc);
  always_comb
  begin
    dig_t_d = MIC_DIG_BLANK;
    dig_o_d = MIC_DIG_ZERO; // see R9
    if (wait_ok)
    begin
      // two digits 01..12, blanked on the off phase
      if (fl_on_q)
      begin
        dig_t_d = (wait_in >= 4'ha) ? MIC_DIG_ONE : MIC_DIG_ZERO; // see R11
        dig_o_d = (wait_in >= 4'ha) ? wait_in - 4'ha : wait_in; // see R11
      end
      else
        dig_o_d = MIC_DIG_BLANK; // see R11
    end
    else if (ctrl_q[MIC_CTRL_PWR_BIT] && ctrl_q[MIC_CTRL_MOTOR_BIT])
      dig_o_d = MIC_DIG_ONE; // see R10
  end
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      dig_t_q <= MIC_DIG_BLANK;
      dig_o_q <= MIC_DIG_ZERO;
    end
    else
    begin
      dig_t_q <= dig_t_d;
      dig_o_q <= dig_o_d;
    end
  end

  mic_seg_enc u_tens (
    .digit(dig_t_q),
    .seg(SEG_TENS)
  );
  mic_seg_enc u_ones (
    .digit(dig_o_q),
    .seg(SEG_ONES)
  );

endmodule // mic_io_top

// >>> verif/mic_plc_model.sv
`timescale 1ns/10ps
// field side: plc inputs and pulled-up output lines
module mic_plc_model
(
  input wire logic [11:0] drive,
  output logic [11:0] plc_in,
  input wire logic [7:0] out_n,
  input wire logic [7:0] out_oe,
  output logic [7:0] line
);
  // code on inputs 9-12, start on input 8
  assign plc_in = drive;
  // released line floats up through the pull-up
  assign line = (out_oe & out_n) | ~out_oe;
endmodule // mic_plc_model

// >>> verif/mic_io_properties.sv
`timescale 1ns/10ps
// port checks of the io block
module mic_io_properties
  import mic_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [11:0] PLC_IN,
  input wire logic [7:0] PLC_OUT_N,
  input wire logic START_PULSE,
  input wire logic [3:0] START_PROG,
  input wire logic [17:0] RS232_BAUD,
  input wire logic [17:0] RS485_BAUD,
  input wire logic [3:0] SERIAL_DATA_BITS,
  input wire logic SERIAL_PARITY_EN,
  input wire logic [1:0] SERIAL_STOP_BITS
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // edges since reset, saturating; rates are latched well before 7
  always_comb cnt_d = (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
  always_ff @(posedge CLK or posedge RESET)
    if (RESET) cnt_q <= 3'h0;
    else cnt_q <= cnt_d;
  a_out_low_only: assert property (PLC_OUT_N == 8'h00)
    else $error("output level not low");
  a_start_code_nz: assert property (START_PULSE |=> START_PROG != 4'h0)
    else $error("start with code zero");
  a_start_single: assert property (START_PULSE |=> !START_PULSE)
    else $error("start pulse too long");
  a_start_cause: assert property (START_PULSE |-> $past(PLC_IN[7], 3))
    else $error("start without input 8");
  a_start_prog_code: assert property (START_PULSE |=>
    START_PROG == $past(PLC_IN[11:8], 4))
    else $error("program number mismatch");
  a_serial_format: assert property (SERIAL_DATA_BITS == 4'h8 && !SERIAL_PARITY_EN
    && SERIAL_STOP_BITS == 2'h1)
    else $error("serial format wrong");
  a_baud_hold: assert property (cnt_q == 3'h7 |->
    $stable(RS232_BAUD) && $stable(RS485_BAUD))
    else $error("rate changed after latch");
  a_err_in_access: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("error outside access");
  a_ready_access: assert property (PSEL && PENABLE |-> PREADY)
    else $error("access not ready");
endmodule // mic_io_properties
bind mic_io_top mic_io_properties u_props (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PLC_IN(PLC_IN),
  .PLC_OUT_N(PLC_OUT_N), .START_PULSE(START_PULSE), .START_PROG(START_PROG),
  .RS232_BAUD(RS232_BAUD), .RS485_BAUD(RS485_BAUD), .SERIAL_DATA_BITS(SERIAL_DATA_BITS),
  .SERIAL_PARITY_EN(SERIAL_PARITY_EN), .SERIAL_STOP_BITS(SERIAL_STOP_BITS));

// >>> verif/tb.sv
`timescale 1ns/10ps
module tb
  import mic_pkg::*;
;
  logic CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SP, e, seen;
  logic [7:0] PADDR, sw, oe, on, line;
  logic [31:0] PWDATA, PRDATA, r, x;
  logic [11:0] in_v, pin;
  logic [6:0] st, so;
  logic [3:0] sprog, db;
  logic [1:0] sb;
  logic par;
  logic [17:0] b2, b4;
  int errors, total_checks;
  localparam logic [17:0] B232 [4] = '{MIC_BAUD_9600, MIC_BAUD_4800, MIC_BAUD_2400,
    MIC_BAUD_19200};
  localparam logic [17:0] B485 [4] = '{MIC_BAUD_19200, MIC_BAUD_9600, MIC_BAUD_38400,
    MIC_BAUD_FREE};
  localparam logic [6:0] SEG [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
    7'h7f, 7'h6f};
  mic_io_top DUT (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PLC_IN(pin), .CONFIG_DIP_SWITCH(sw), .PLC_OUT_N(on), .PLC_OUT_OE(oe), .SEG_TENS(st),
    .SEG_ONES(so), .START_PULSE(SP), .START_PROG(sprog), .RS232_BAUD(b2), .RS485_BAUD(b4),
    .SERIAL_DATA_BITS(db), .SERIAL_PARITY_EN(par), .SERIAL_STOP_BITS(sb));
  mic_plc_model u_plc (.drive(in_v), .plc_in(pin), .out_n(on), .out_oe(oe), .line(line));
  function logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // expected display: steady digit, or two flashing digits
  function logic [13:0] dexp(input int n, input logic w);
    return w ? {SEG[n / 10], SEG[n % 10]} : {7'h00, SEG[n]};
  endfunction
  function logic [17:0] baud(input int k, input logic s);
    return s ? B485[k] : B232[k];
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] w);
    total_checks++;
    if (g !== w)
    begin
      errors++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, w);
    end
  endtask
  // one apb transfer; idle edge after so no signal is set twice per step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    // no assumed latency: a hung slave is ended by the watchdog
    while (PREADY !== 1'b1)
      @(posedge CLK);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task rst;
    RESET <= 1'b1;
    repeat (6) @(posedge CLK);
    RESET <= 1'b0;
    repeat (6) @(posedge CLK);
  endtask
  // flash phase is free running, so a blank pair is accepted while waiting
  task disp(input logic [31:0] c, input int n, input logic w);
    apb(1'b1, MIC_ADDR_CTRL, c);
    repeat (3) @(posedge CLK);
    chk((w && {st, so} === 14'h0) ? dexp(n, w) : {st, so}, dexp(n, w));
  endtask
  task strt(input logic [3:0] c, input logic ex);
    in_v <= {c, 8'h00};
    repeat (4) @(posedge CLK);
    in_v[7] <= 1'b1;
    seen = 1'b0;
    repeat (8)
    begin
      @(posedge CLK);
      seen = seen | SP;
    end
    chk(seen, ex);
    if (ex) chk(sprog, c);
    in_v[7] <= 1'b0;
    repeat (4) @(posedge CLK);
  endtask
  task summarize;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  initial
  begin
    #200000;
    errors++;
    summarize;
  end
  initial
  begin
    {RESET, PSEL, PENABLE, PWRITE, PADDR, PWDATA, in_v, sw} = '0;
    x = 32'hc935;
    // each switch pair setting, latched only across a reset
    for (int i = 0; i < 4; i++)
    begin
      x = lfsr(x);
      sw <= {i[0], i[1], i[1], i[0], x[3:0]};
      rst;
      chk(b2, baud(i, 1'b0));
      chk(b4, baud(i, 1'b1));
      sw <= ~sw;
      repeat (8) @(posedge CLK);
      chk(b2, baud(i, 1'b0));
      chk(b4, baud(i, 1'b1));
    end
    apb(1'b0, MIC_ADDR_BAUD, 32'h0);
    chk(r, {14'h0, 4'hf, B232[3][17:4]});
    chk({db, par, sb}, {4'h8, 1'b0, 2'h1});
    $display("test baud done");
    chk(oe, 8'h00);
    disp(32'h00, 0, 1'b0);
    disp(32'h10, 0, 1'b0);
    disp(32'h30, 1, 1'b0);
    for (int n = 1; n <= 12; n++) disp(32'h100 | (n << 12), n, 1'b1);
    $display("test display done");
    repeat (4)
    begin
      x = lfsr(x);
      apb(1'b1, MIC_ADDR_OUT, {24'h0, x[7:0]});
      chk({oe, line}, {x[7:0], ~x[7:0]});
      apb(1'b0, MIC_ADDR_OUT, 32'h0);
      chk(r, {24'h0, x[7:0]});
    end
    $display("test outputs done");
    apb(1'b1, MIC_ADDR_CTRL, 32'h3);
    in_v <= x[19:8] & 12'hf7f;
    repeat (4) @(posedge CLK);
    apb(1'b0, MIC_ADDR_IN, 32'h0);
    chk(r, {20'h0, x[19:8] & 12'hf7f});
    strt(4'h5, 1'b0);
    apb(1'b1, MIC_ADDR_CTRL, {28'h0, MIC_MODE_CODED});
    in_v <= x[19:8] & 12'hf7f;
    repeat (4) @(posedge CLK);
    apb(1'b0, MIC_ADDR_IN, 32'h0);
    chk(r, {24'h0, x[15:8] & 8'h7f});
    for (int c = 0; c < 16; c++) strt(c[3:0], c != 0);
    apb(1'b0, MIC_ADDR_START, 32'h0);
    chk(r, {24'h0, 4'hf, 4'hf});
    $display("test start done");
    apb(1'b1, 8'h18, x);
    chk(e, 1'b1);
    apb(1'b0, 8'h18, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    $display("test unmapped done");
    summarize;
  end
endmodule // tb
